// *** power_good_output_clk_pin_defs.svh ***
// How it works
// - Bits 3:0 hold one latched fault flag per converter phase.
// - Reading fault register clears a flag only while that phase is valid.
// - Clock mode 0 runs internal oscillator, multiplier off; code 3 reserved.
// - Mode 1 keeps multiplier on in standby and active, uses external clock.
// - Mode 2 enables multiplier only when active, uses external clock.
// - Multiplier modes pulse an event when external clock appears or vanishes.
// - Role register bit 7 switches spread-spectrum modulation on or off.
// - Role bits 2:0 pick enable function or general I/O per pin.
// - Bit 6 gates I/O 3 output level with a chosen enable pin.
// - Bit 5 picks first (0) or second (1) enable pin for I/O 3.
// - Bit 4 gates I/O 2 output level with a chosen enable pin.
// - Bit 3 picks first (0) or third (1) enable pin for I/O 2.
// - Drive bits 6:4 choose push-pull or open-drain for I/O 3..1.
// - Drive bits 2:0 set I/O direction; gating only on outputs.
// - Input register bits 2:0 show pin levels; bits 7:3 read zero.
// - Output-level bits 2:0 set driven level of I/O 3..1.
// - Latched mode makes power-good inactive while any fault flag is set.
`ifndef POWER_GOOD_OUTPUT_CLK_PIN_DEFS_SVH
`define POWER_GOOD_OUTPUT_CLK_PIN_DEFS_SVH

`define IDX_FAULT_SRC 6'h2a
`define IDX_CLK_CTRL 6'h2b
`define IDX_PIN_ROLE 6'h2c
`define IDX_PIN_DRIVE 6'h2d
`define IDX_PIN_IN 6'h2e
`define IDX_PIN_OUT 6'h2f
`define IDX_PG_MODE 6'h30

`define CLK_MODE_HI 7
`define CLK_MODE_LO 6
`define EXT_RATE_HI 4
`define SPREAD_BIT 7
`define IO3_GATE_ON_BIT 6
`define IO3_GATE_PICK_BIT 5
`define IO2_GATE_ON_BIT 4
`define IO2_GATE_PICK_BIT 3
`define ROLE_HI 2
`define OD_HI 6
`define OD_LO 4
`define DIR_HI 2
`define PG_MODE_BIT 0

`define RST_CLK_CTRL 8'h00
`define RST_PIN_ROLE 8'h00
`define RST_PIN_OD 3'h0
`define RST_PIN_DIR 3'h0
`define RST_PIN_OUT 3'h0
`define RST_PG_MODE 1'h0
`define RST_FAULT 4'h0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** power_good_output_clk_pin_pkg.sv ***
package power_good_output_clk_pin_pkg;

  typedef enum logic [1:0] {
    CLK_INTERNAL = 2'b00,
    CLK_MULT_ALWAYS = 2'b01,
    CLK_MULT_ACTIVE = 2'b10,
    CLK_RESERVED = 2'b11
  } clk_mode_t;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic multiplier_en;
    logic use_ext_clk;
    logic spread_spectrum_on;
    logic [4:0] external_clock_rate;
  } clk_ctrl_t;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } pin_drive_t;

endpackage : power_good_output_clk_pin_pkg

// *** level_sync.sv ***
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule : level_sync

// *** power_good_output_clock_pin_gpio_regs.sv ***
`timescale 1ns/1ps
`include "power_good_output_clk_pin_defs.svh"
module power_good_output_clock_pin_gpio_regs #(
  parameter int PHASES = 4,
  parameter int PINS = 3
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire power_good_output_clk_pin_pkg::axil_req_t axi_req_i,
  output power_good_output_clk_pin_pkg::axil_rsp_t axi_rsp_o,
  input wire logic [PHASES-1:0] phase_valid_i,
  input wire logic device_active_i,
  input wire logic ext_clk_present_i,
  input wire logic [PINS-1:0] pin_i,
  output power_good_output_clk_pin_pkg::pin_drive_t pin_o,
  output logic [PINS-1:0] enable_level_o,
  output power_good_output_clk_pin_pkg::clk_ctrl_t clk_ctrl_o,
  output logic clk_change_event_o,
  output logic power_good_o
);

  // Register state
  logic [3:0] fault_ff;
  logic [3:0] nxt_fault;
  logic [3:0] prev_valid_ff;
  logic [7:0] clk_ctrl_ff;
  logic [7:0] role_ff;
  logic [2:0] od_ff;
  logic [2:0] dir_ff;
  logic [2:0] out_ff;
  logic pg_mode_ff;
  logic power_good_ff;
  logic ext_prev_ff;
  logic clk_event_ff;
  power_good_output_clk_pin_pkg::clk_ctrl_t clk_out_ff;
  power_good_output_clk_pin_pkg::pin_drive_t pin_drv_ff;
  logic [2:0] enable_ff;

  // Bus slave state
  logic aw_got_ff;
  logic [7:0] awaddr_ff;
  logic w_got_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Pin and clock-present synchronisation
  logic [3:0] sync_w;

  level_sync #(
    .WIDTH(4)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({ext_clk_present_i, pin_i[2:0]}),
    .sync_o(sync_w)
  );

  wire [2:0] pin_sync_w = sync_w[2:0];
  wire ext_sync_w = sync_w[3];

  // AXI4-Lite write path
  wire aw_take_w = axi_req_i.awvalid & ~aw_got_ff & ~bvalid_ff;
  wire w_take_w = axi_req_i.wvalid & ~w_got_ff & ~bvalid_ff;
  wire do_write_w = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire [5:0] wr_idx_w = awaddr_ff[7:2];
  wire wr_lane_w = do_write_w & wstrb_ff[0];
  wire wr_hit_w = (wr_idx_w >= `IDX_FAULT_SRC) & (wr_idx_w <= `IDX_PG_MODE);
  wire wr_clk_w = wr_lane_w & (wr_idx_w == `IDX_CLK_CTRL);
  wire wr_role_w = wr_lane_w & (wr_idx_w == `IDX_PIN_ROLE);
  wire wr_drive_w = wr_lane_w & (wr_idx_w == `IDX_PIN_DRIVE);
  wire wr_out_w = wr_lane_w & (wr_idx_w == `IDX_PIN_OUT);
  wire wr_pg_w = wr_lane_w & (wr_idx_w == `IDX_PG_MODE);

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end
    else
    begin
      if (aw_take_w)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= axi_req_i.awaddr;
      end
      else if (do_write_w)
        aw_got_ff <= 1'b0;
      if (w_take_w)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= axi_req_i.wdata;
        wstrb_ff <= axi_req_i.wstrb;
      end
      else if (do_write_w)
        w_got_ff <= 1'b0;
      if (do_write_w)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit_w ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (axi_req_i.bready)
        bvalid_ff <= 1'b0;
    end
  end

  // AXI4-Lite read path
  wire ar_take_w = axi_req_i.arvalid & ~rvalid_ff;
  wire [5:0] rd_idx_w = axi_req_i.araddr[7:2];
  wire rd_fault_w = ar_take_w & (rd_idx_w == `IDX_FAULT_SRC);
  wire [7:0] rd_fault_val_w = {4'h0, fault_ff};
  wire [7:0] rd_clk_val_w = {clk_ctrl_ff[7:6], 1'b0, clk_ctrl_ff[4:0]};
  wire [7:0] rd_drive_val_w = {1'b0, od_ff, 1'b0, dir_ff};
  wire [7:0] rd_in_val_w = {5'h00, pin_sync_w};
  wire [7:0] rd_out_val_w = {5'h00, out_ff};
  wire [7:0] rd_pg_val_w = {7'h00, pg_mode_ff};
  wire rd_hit_w = (rd_idx_w >= `IDX_FAULT_SRC) & (rd_idx_w <= `IDX_PG_MODE);
  wire [7:0] rd_mux_w =
    (rd_idx_w == `IDX_FAULT_SRC) ? rd_fault_val_w :
    (rd_idx_w == `IDX_CLK_CTRL) ? rd_clk_val_w :
    (rd_idx_w == `IDX_PIN_ROLE) ? role_ff :
    (rd_idx_w == `IDX_PIN_DRIVE) ? rd_drive_val_w :
    (rd_idx_w == `IDX_PIN_IN) ? rd_in_val_w :
    (rd_idx_w == `IDX_PIN_OUT) ? rd_out_val_w :
    (rd_idx_w == `IDX_PG_MODE) ? rd_pg_val_w : 8'h00;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `RESP_OKAY;
    end
    else if (ar_take_w)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_mux_w};
      rresp_ff <= rd_hit_w ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (axi_req_i.rready)
      rvalid_ff <= 1'b0;
  end

  assign axi_rsp_o.awready = ~aw_got_ff & ~bvalid_ff;
  assign axi_rsp_o.wready = ~w_got_ff & ~bvalid_ff;
  assign axi_rsp_o.bvalid = bvalid_ff;
  assign axi_rsp_o.bresp = bresp_ff;
  assign axi_rsp_o.arready = ~rvalid_ff;
  assign axi_rsp_o.rvalid = rvalid_ff;
  assign axi_rsp_o.rdata = rdata_ff;
  assign axi_rsp_o.rresp = rresp_ff;

  // Software registers
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      clk_ctrl_ff <= `RST_CLK_CTRL;
      role_ff <= `RST_PIN_ROLE;
      od_ff <= `RST_PIN_OD;
      dir_ff <= `RST_PIN_DIR;
      out_ff <= `RST_PIN_OUT;
      pg_mode_ff <= `RST_PG_MODE;
    end
    else
    begin
      // Rate codes 18h..1Fh are stored as written; software keeps them out
      if (wr_clk_w)
        clk_ctrl_ff <= wdata_ff[7:0];
      if (wr_role_w)
        role_ff <= wdata_ff[7:0];
      if (wr_drive_w)
      begin
        od_ff <= wdata_ff[`OD_HI:`OD_LO];
        dir_ff <= wdata_ff[`DIR_HI:0];
      end
      if (wr_out_w)
        out_ff <= wdata_ff[2:0];
      if (wr_pg_w)
        pg_mode_ff <= wdata_ff[`PG_MODE_BIT];
    end
  end

  // Fault-source flags
  wire [3:0] drop_w = prev_valid_ff & ~phase_valid_i;
  wire [3:0] clr_w = rd_fault_w ? phase_valid_i : 4'h0;

  // Set ORed after clear so a drop during a read survives
  assign nxt_fault = drop_w | (fault_ff & ~clr_w);

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      fault_ff <= `RST_FAULT;
      prev_valid_ff <= 4'h0;
      power_good_ff <= 1'b0;
    end
    else
    begin
      fault_ff <= nxt_fault;
      prev_valid_ff <= phase_valid_i;
      power_good_ff <= pg_mode_ff ? ~|fault_ff : &phase_valid_i;
    end
  end

  assign power_good_o = power_good_ff;

  // Switching clock source selection
  power_good_output_clk_pin_pkg::clk_mode_t mode_w;
  logic mult_en_w;
  logic mult_mode_w;

  assign mode_w = power_good_output_clk_pin_pkg::clk_mode_t'(clk_ctrl_ff[`CLK_MODE_HI:`CLK_MODE_LO]);

  always_comb
  begin
    mult_en_w = 1'b0;
    mult_mode_w = 1'b0;
    unique case (mode_w)
      // Reserved code falls back to the safe internal oscillator
      power_good_output_clk_pin_pkg::CLK_INTERNAL, power_good_output_clk_pin_pkg::CLK_RESERVED:
      begin
        mult_en_w = 1'b0;
        mult_mode_w = 1'b0;
      end
      power_good_output_clk_pin_pkg::CLK_MULT_ALWAYS:
      begin
        mult_en_w = 1'b1;
        mult_mode_w = 1'b1;
      end
      power_good_output_clk_pin_pkg::CLK_MULT_ACTIVE:
      begin
        mult_en_w = device_active_i;
        mult_mode_w = 1'b1;
      end
    endcase
  end

  wire ext_change_w = ext_sync_w ^ ext_prev_ff;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      ext_prev_ff <= 1'b0;
      clk_event_ff <= 1'b0;
      clk_out_ff <= '0;
    end
    else
    begin
      ext_prev_ff <= ext_sync_w;
      clk_event_ff <= mult_mode_w & ext_change_w;
      clk_out_ff.multiplier_en <= mult_en_w;
      clk_out_ff.use_ext_clk <= mult_en_w & ext_sync_w;
      clk_out_ff.spread_spectrum_on <= role_ff[`SPREAD_BIT];
      clk_out_ff.external_clock_rate <= clk_ctrl_ff[`EXT_RATE_HI:0];
    end
  end

  assign clk_ctrl_o = clk_out_ff;
  assign clk_change_event_o = clk_event_ff;

  // Pin multiplexing and drive
  wire io3_gate_w = role_ff[`IO3_GATE_PICK_BIT] ? pin_sync_w[1] : pin_sync_w[0];
  wire io2_gate_w = role_ff[`IO2_GATE_PICK_BIT] ? pin_sync_w[2] : pin_sync_w[0];
  wire [2:0] level_w;
  wire [2:0] driving_w = role_ff[`ROLE_HI:0] & dir_ff;

  assign level_w[0] = out_ff[0];
  assign level_w[1] = out_ff[1] & (~role_ff[`IO2_GATE_ON_BIT] | io2_gate_w);
  assign level_w[2] = out_ff[2] & (~role_ff[`IO3_GATE_ON_BIT] | io3_gate_w);

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_drv_ff <= '0;
      enable_ff <= 3'h0;
    end
    else
    begin
      // Open-drain only pulls low, never drives high
      pin_drv_ff.oe <= driving_w & (~od_ff | ~level_w);
      pin_drv_ff.out <= level_w & ~od_ff;
      enable_ff <= pin_sync_w & ~role_ff[`ROLE_HI:0];
    end
  end

  assign pin_o = pin_drv_ff;
  assign enable_level_o = enable_ff;

  property p_fault_set;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (drop_w != 4'h0) |=> ((fault_ff & $past(drop_w)) == $past(drop_w));
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault flag not set on phase drop");
  property p_fault_clear;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (rd_fault_w && ((phase_valid_i & prev_valid_ff) != 4'h0))
        |=> ((fault_ff & $past(phase_valid_i & prev_valid_ff)) == 4'h0);
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault flag not cleared by read while valid");
  property p_fault_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      ((fault_ff & ~phase_valid_i) != 4'h0)
        |=> ((fault_ff & $past(fault_ff & ~phase_valid_i)) == $past(fault_ff & ~phase_valid_i));
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault flag lost while phase invalid");
  property p_internal_mode;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (clk_ctrl_ff[7:6] == 2'h0) ##1 (clk_ctrl_ff[7:6] == 2'h0)
        |-> (!clk_ctrl_o.multiplier_en && !clk_ctrl_o.use_ext_clk);
  endproperty
  a_internal_mode: assert property (p_internal_mode)
    else $error("multiplier on in internal mode");
  property p_mode_always;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (clk_ctrl_ff[7:6] == 2'h1 && ext_sync_w) |=> (clk_ctrl_o.use_ext_clk && clk_ctrl_o.multiplier_en);
  endproperty
  a_mode_always: assert property (p_mode_always)
    else $error("external clock not used in mode 1");
  property p_mode_active;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (clk_ctrl_ff[7:6] == 2'h2) |=> (clk_ctrl_o.multiplier_en == $past(device_active_i));
  endproperty
  a_mode_active: assert property (p_mode_active)
    else $error("multiplier not following active state in mode 2");
  property p_clk_event;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      ($changed(ext_sync_w) && clk_ctrl_ff[7:6] != 2'h0 && clk_ctrl_ff[7:6] != 2'h3)
        ##1 (1'b1) |-> clk_change_event_o;
  endproperty
  a_clk_event: assert property (p_clk_event)
    else $error("no event on external clock change");
  property p_io3_gate;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (driving_w[2] && !od_ff[2] && role_ff[6] && !io3_gate_w) |=> !pin_o.out[2];
  endproperty
  a_io3_gate: assert property (p_io3_gate)
    else $error("io3 driven high with gating pin low");
  property p_pg_latched;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (pg_mode_ff && fault_ff != 4'h0) |=> !power_good_o;
  endproperty
  a_pg_latched: assert property (p_pg_latched)
    else $error("power good active with fault latched");

endmodule : power_good_output_clock_pin_gpio_regs

// *** pin_far_side_model.sv ***
`timescale 1ns/1ps
module pin_far_side_model (
  input wire power_good_output_clk_pin_pkg::pin_drive_t drive_i,
  input wire logic [2:0] far_level_i,
  output logic [2:0] pin_level_o
);
  // Released or open-drain high pins show the far side level
  assign pin_level_o = (drive_i.oe & drive_i.out) | (~drive_i.oe & far_level_i);
endmodule : pin_far_side_model

// *** power_good_output_clock_pin_gpio_regs_tb_top.sv ***
`timescale 1ns/1ps
`include "power_good_output_clk_pin_defs.svh"
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module power_good_output_clock_pin_gpio_regs_tb_top;
  localparam logic [7:0] A_FLT = {`IDX_FAULT_SRC, 2'b00};
  localparam logic [7:0] A_CLK = {`IDX_CLK_CTRL, 2'b00};
  localparam logic [7:0] A_ROLE = {`IDX_PIN_ROLE, 2'b00};
  localparam logic [7:0] A_DRV = {`IDX_PIN_DRIVE, 2'b00};
  localparam logic [7:0] A_IN = {`IDX_PIN_IN, 2'b00};
  localparam logic [7:0] A_OUT = {`IDX_PIN_OUT, 2'b00};
  localparam logic [7:0] A_MODE = {`IDX_PG_MODE, 2'b00};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  power_good_output_clk_pin_pkg::axil_req_t req = '0;
  power_good_output_clk_pin_pkg::axil_rsp_t rsp;
  logic [3:0] phase_valid = 4'hf;
  logic active = 1'b1;
  logic ext_present = 1'b0;
  logic [2:0] far_level = 3'h0;
  logic [2:0] pin_level;
  power_good_output_clk_pin_pkg::pin_drive_t pin_drv;
  logic [2:0] en_level;
  power_good_output_clk_pin_pkg::clk_ctrl_t clk_ctrl;
  logic clk_evt;
  logic power_good_output;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] rd;
  logic [1:0] rs;

  always #2 ref_clk = ~ref_clk;

  power_good_output_clock_pin_gpio_regs dut_u (
    .ref_clk_i(ref_clk),
    .sys_rst_i(sys_rst),
    .axi_req_i(req),
    .axi_rsp_o(rsp),
    .phase_valid_i(phase_valid),
    .device_active_i(active),
    .ext_clk_present_i(ext_present),
    .pin_i(pin_level),
    .pin_o(pin_drv),
    .enable_level_o(en_level),
    .clk_ctrl_o(clk_ctrl),
    .clk_change_event_o(clk_evt),
    .power_good_o(power_good_output)
  );

  pin_far_side_model far_u (
    .drive_i(pin_drv),
    .far_level_i(far_level),
    .pin_level_o(pin_level)
  );

  task automatic conclude;
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // Handshakes are judged at the falling edge, where outputs are settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic at;
    logic wt;
    logic bt;
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    bt = 1'b0;
    while (!bt)
    begin
      @(negedge ref_clk);
      at = req.awvalid & rsp.awready;
      wt = req.wvalid & rsp.wready;
      bt = rsp.bvalid;
      r = rsp.bresp;
      @(posedge ref_clk);
      if (at)
        req.awvalid <= 1'b0;
      if (wt)
        req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    logic t;
    logic v;
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    v = 1'b0;
    while (!v)
    begin
      @(negedge ref_clk);
      t = req.arvalid & rsp.arready;
      v = rsp.rvalid;
      d = rsp.rdata[7:0];
      r = rsp.rresp;
      @(posedge ref_clk);
      if (t)
        req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
  endtask : rdr

  task automatic t_reset;
    rdr(A_FLT, rd, rs);
    `CHK("fault reg", 8'h00, rd)
    rdr(A_IN, rd, rs);
    `CHK("input reg", 8'h00, rd)
    rdr(8'hfc, rd, rs);
    `CHK("unmapped read", `RESP_SLVERR, rs)
    wr(8'hfc, 8'hff, rs);
    `CHK("unmapped write", `RESP_SLVERR, rs)
  endtask : t_reset

  task automatic t_clock;
    logic [1:0] m;
    logic em;
    ext_present <= 1'b1;
    for (int a = 0; a < 2; a++)
    begin
      active <= a[0];
      for (int i = 0; i < 4; i++)
      begin
        m = i[1:0];
        wr(A_CLK, {m, 1'b0, 5'h17}, rs);
        repeat (4) @(posedge ref_clk);
        em = (m == 2'h1) | ((m == 2'h2) & a[0]);
        `CHK("multiplier", em, clk_ctrl.multiplier_en)
        `CHK("external use", em, clk_ctrl.use_ext_clk)
        `CHK("rate", 5'h17, clk_ctrl.external_clock_rate)
        rdr(A_CLK, rd, rs);
        `CHK("clock reg", {m, 1'b0, 5'h17}, rd)
      end
    end
    active <= 1'b1;
  endtask : t_clock

  task automatic t_event;
    int n;
    for (int i = 0; i < 2; i++)
    begin
      wr(A_CLK, (i == 0) ? 8'h40 : 8'h00, rs);
      ext_present <= ~ext_present;
      n = 0;
      repeat (8)
      begin
        @(negedge ref_clk);
        if (clk_evt === 1'b1)
          n++;
      end
      `CHK("clock events", (i == 0) ? 1 : 0, n)
    end
  endtask : t_event

  // Pin 1 stays an enable input through the six gating cases so it can gate the other two; role 87h later makes it an output
  task automatic t_pins;
    logic [7:0] role [6] = '{8'h06, 8'h46, 8'h46, 8'h66, 8'h16, 8'h1e};
    logic [2:0] lvl [6] = '{3'h6, 3'h6, 3'h6, 3'h4, 3'h6, 3'h6};
    logic [1:0] want [6] = '{2'h3, 2'h1, 2'h3, 2'h0, 2'h2, 2'h3};
    logic [5:0] ext0 = 6'b001100;
    wr(A_DRV, 8'h06, rs);
    for (int i = 0; i < 6; i++)
    begin
      wr(A_ROLE, role[i], rs);
      wr(A_OUT, {5'h00, lvl[i]}, rs);
      far_level <= {2'b00, ext0[i]};
      repeat (12) @(posedge ref_clk);
      `CHK("gated out", {want[i], 1'b0}, pin_drv.out)
      `CHK("drive enable", 3'h6, pin_drv.oe)
      `CHK("enable level", {2'b00, ext0[i]}, en_level)
    end
    wr(A_ROLE, 8'h87, rs);
    wr(A_DRV, 8'h17, rs);
    wr(A_OUT, 8'h05, rs);
    far_level <= 3'h3;
    repeat (6) @(posedge ref_clk);
    `CHK("od release", 3'h6, pin_drv.oe)
    `CHK("od out", 3'h4, pin_drv.out)
    `CHK("spread on", 1'b1, clk_ctrl.spread_spectrum_on)
    rdr(A_IN, rd, rs);
    `CHK("input levels", 8'h05, rd)
    rdr(A_DRV, rd, rs);
    `CHK("drive reg", 8'h17, rd)
    wr(A_OUT, 8'h04, rs);
    repeat (6) @(posedge ref_clk);
    rdr(A_IN, rd, rs);
    `CHK("od low", 8'h04, rd)
    wr(A_ROLE, 8'h07, rs);
    repeat (2) @(posedge ref_clk);
    `CHK("spread off", 1'b0, clk_ctrl.spread_spectrum_on)
  endtask : t_pins

  task automatic t_fault;
    wr(A_MODE, 8'h01, rs);
    phase_valid <= 4'hb;
    repeat (3) @(posedge ref_clk);
    `CHK("power_good_output latched", 1'b0, power_good_output)
    rdr(A_FLT, rd, rs);
    `CHK("fault flag", 8'h04, rd)
    rdr(A_FLT, rd, rs);
    `CHK("flag kept", 8'h04, rd)
    phase_valid <= 4'hf;
    repeat (3) @(posedge ref_clk);
    `CHK("power_good_output held", 1'b0, power_good_output)
    rdr(A_FLT, rd, rs);
    `CHK("pre clear", 8'h04, rd)
    rdr(A_FLT, rd, rs);
    `CHK("cleared", 8'h00, rd)
    repeat (3) @(posedge ref_clk);
    `CHK("power_good_output back", 1'b1, power_good_output)
    // Phase 3 drops on the very cycle the read is taken
    fork
      rdr(A_FLT, rd, rs);
      begin
        @(posedge ref_clk);
        phase_valid <= 4'h7;
      end
    join
    `CHK("drop at read", 8'h00, rd)
    rdr(A_FLT, rd, rs);
    `CHK("set wins", 8'h08, rd)
  endtask : t_fault

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_clock();
    t_event();
    t_pins();
    t_fault();
    conclude();
  end
endmodule : power_good_output_clock_pin_gpio_regs_tb_top
